// ### hw/serial_channel_params.svh
// Summary of operation
// R1: Decode sixteen consecutive ports at any sixteen-aligned base; functions sit at fixed offsets.
// R2: Offset twelve reads the last received character; writes queue a character to send.
// R3: Offset thirteen reads the eight-bit status register; writes there do nothing.
// R4: Offset fourteen writes mode bytes and reads back the current mode settings.
// R5: Offset fifteen writes the command register and reads back the command in effect.
// R6: Transmit adds start and stop bits; receive strips them before presenting the character.
// R7: Baud, length, parity, stop bits, enables and modem lines are all programmable.
// R8: Status bit 0 high when the transmitter can take a new character.
// R9: Host writes data only while status bit 0 reads high.
// R10: Status bit 1 high while a received character waits to be read.
// R11: Status bit 2 high on carrier or data-set-ready change, or shifter empty.
// R12: Status bit 3 set when a received character fails its parity check.
// R13: Status bit 4 set when a character arrives before the previous was read.
// R14: Status bit 5 set when no valid stop bit is sampled.
// R15: Status bit 6 reads the carrier-detect line inverted.
// R16: Status bit 7 reads the data-set-ready line inverted.
// R17: Command write with bit 4 set clears parity, overrun and framing flags.
// R18: Mode port writes go to mode one then mode two, in that order.
// R19: Command bit 0 enables the transmitter, command bit 2 enables the receiver.
// R20: Data read clears receive-ready; data write clears transmit-ready until the shifter takes it.
// R21: Error flags stay set until cleared by command or by reset.
`ifndef SERIAL_CHANNEL_PARAMS_SVH
`define SERIAL_CHANNEL_PARAMS_SVH

`define SER_OFS_DATA 4'hC
`define SER_OFS_STATUS 4'hD
`define SER_OFS_MODE 4'hE
`define SER_OFS_CMD 4'hF

`define SER_ST_TRANSMIT_HOLDING_FREE 0
`define SER_ST_RECEIVE_CHAR_AVAILABLE 1
`define SER_ST_TXEMT 2
`define SER_ST_PERR 3
`define SER_ST_OVR 4
`define SER_ST_FERR 5
`define SER_ST_DCD 6
`define SER_ST_DSR 7

`define SER_CMD_TXEN 0
`define SER_CMD_DTR 1
`define SER_CMD_RXEN 2
`define SER_CMD_BREAK 3
`define SER_CMD_ERRCLR 4
`define SER_CMD_RTS 5

`define SER_M1_LEN 3:2
`define SER_M1_PAREN 4
`define SER_M1_PAREVEN 5
`define SER_M1_STOP 7:6
`define SER_M2_RATE 3:0

`define SER_RESET_BYTE 8'h00
`define SER_CLK_HZ 50000000
`define SER_OVERSAMPLE 16
`define SER_MID_TICK 6'h07
`define SER_LAST_TICK 6'h0F
`define SER_STOP_ONE 6'h10
`define SER_STOP_ONEHALF 6'h18
`define SER_STOP_TWO 6'h20
`define SER_MIN_LEN 4'h5

`endif

// ### hw/serial_channel_pkg.sv
package serial_channel_pkg;
   typedef enum logic [2:0] {
      LINE_IDLE = 3'b000,
      LINE_START = 3'b001,
      LINE_DATA = 3'b011,
      LINE_PARITY = 3'b010,
      LINE_STOP = 3'b110
   } line_state_t;
endpackage : serial_channel_pkg

// ### hw/baud_tick_gen.sv
`include "serial_channel_params.svh"
module baud_tick_gen
   import serial_channel_pkg::*;
#(
   parameter int CLK_HZ = `SER_CLK_HZ
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Rate select and sixteen-times enable.
   input wire logic [3:0] rate_sel,
   output logic tick_q
);
   logic [15:0] count_q, count_d;
   logic tick_d;
   logic [15:0] divisor;

   // Rates are held in tenths of a baud so the 134.5 entry stays exact.
   function automatic logic [15:0] rate_divisor(input logic [3:0] sel);
      int tenths;
      unique case (sel)
         4'h0: tenths = 500;
         4'h1: tenths = 750;
         4'h2: tenths = 1100;
         4'h3: tenths = 1345;
         4'h4: tenths = 1500;
         4'h5: tenths = 3000;
         4'h6: tenths = 6000;
         4'h7: tenths = 12000;
         4'h8: tenths = 18000;
         4'h9: tenths = 20000;
         4'hA: tenths = 24000;
         4'hB: tenths = 36000;
         4'hC: tenths = 48000;
         4'hD: tenths = 72000;
         4'hE: tenths = 96000;
         4'hF: tenths = 192000;
      endcase
      rate_divisor = 16'((longint'(CLK_HZ) * 10) / (tenths * `SER_OVERSAMPLE));
   endfunction : rate_divisor

   always_comb begin
      divisor = rate_divisor(rate_sel);
      tick_d = 1'b0;
      count_d = count_q + 16'h0001;
      if (count_q >= divisor - 16'h0001) begin
         count_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         count_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end
endmodule : baud_tick_gen

// ### hw/char_skid_buffer.sv
module char_skid_buffer #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   input wire logic out_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot_q [2];
   logic [WIDTH-1:0] slot_d [2];
   logic rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
   logic [1:0] fill_q, fill_d;
   logic push, pop;

   always_comb begin
      in_ready = (fill_q != 2'h2);
      out_valid = (fill_q != 2'h0);
      out_data = slot_q[rd_ptr_q];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      slot_d = slot_q;
      if (push) begin
         slot_d[wr_ptr_q] = in_data;
      end
      wr_ptr_d = wr_ptr_q ^ push;
      rd_ptr_d = rd_ptr_q ^ pop;
      fill_d = fill_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         fill_q <= 2'h0;
         slot_q <= '{default: '0};
      end else begin
         rd_ptr_q <= rd_ptr_d;
         wr_ptr_q <= wr_ptr_d;
         fill_q <= fill_d;
         slot_q <= slot_d;
      end
   end
endmodule : char_skid_buffer

// ### hw/serial_channel_register_port.sv
`include "serial_channel_params.svh"
module serial_channel_register_port
   import serial_channel_pkg::*;
#(
   parameter int CLK_HZ = `SER_CLK_HZ
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Host port bus.
   input wire logic [3:0] base_sel,
   input wire logic [7:0] port_addr,
   input wire logic [7:0] port_wdata,
   input wire logic port_wr,
   input wire logic port_rd,
   output logic [7:0] port_rdata_q,
   // Serial line and modem lines.
   input wire logic rxd,
   input wire logic dcd_n,
   input wire logic dsr_n,
   output logic txd_q,
   output logic rts_n_q,
   output logic dtr_n_q
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] mode1_q, mode1_d, mode2_q, mode2_d, cmd_q, cmd_d;
   logic mode_ptr_q, mode_ptr_d;
   logic [7:0] rx_hold_q, rx_hold_d, rdata_d;
   logic rx_avail_q, rx_avail_d, perr_q, perr_d, ovr_q, ovr_d, ferr_q, ferr_d;
   logic modem_chg_q, modem_chg_d, dcd_last_q, dsr_last_q;
   logic txd_d, rts_n_d, dtr_n_d;
   logic hit, wr_data, rd_data, rd_stat, wr_mode, rd_mode, wr_cmd;
   logic [7:0] status;
   logic tick;
   logic [3:0] char_len;
   logic [7:0] len_mask;
   logic [5:0] stop_ticks;
   logic buf_out_valid, buf_out_ready;
   logic [7:0] buf_out_data;
   logic tx_en, rx_en, tx_free, tx_empty;

   baud_tick_gen #(.CLK_HZ(CLK_HZ)) u_baud (
      .clock(clock),
      .resetn(resetn),
      .rate_sel(mode2_q[`SER_M2_RATE]),
      .tick_q(tick)
   );

   // A write while the holding stage is not free still lands if there is room.
   char_skid_buffer #(.WIDTH(8)) u_txbuf (
      .clock(clock),
      .resetn(resetn),
      .in_valid(wr_data),
      .in_ready(),
      .in_data(port_wdata),
      .out_ready(buf_out_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Mode one and command decoding used by the line engines.
   function automatic logic calc_parity(input logic [7:0] d, input logic even);
      calc_parity = even ? ^d : ~^d;
   endfunction : calc_parity

   always_comb begin
      char_len = `SER_MIN_LEN + {2'b00, mode1_q[`SER_M1_LEN]}; // R7
      len_mask = 8'((9'h001 << char_len) - 9'h001);
      unique case (mode1_q[`SER_M1_STOP])
         2'b10: stop_ticks = `SER_STOP_ONEHALF;
         2'b11: stop_ticks = `SER_STOP_TWO;
         default: stop_ticks = `SER_STOP_ONE;
      endcase
      tx_en = cmd_q[`SER_CMD_TXEN]; // R19
      rx_en = cmd_q[`SER_CMD_RXEN]; // R19
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmitter.
   line_state_t tx_st_q, tx_st_d;
   logic [5:0] tx_cnt_q, tx_cnt_d;
   logic [3:0] tx_idx_q, tx_idx_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic tx_bit;

   always_comb begin
      tx_st_d = tx_st_q;
      tx_cnt_d = tx_cnt_q;
      tx_idx_d = tx_idx_q;
      tx_sh_d = tx_sh_q;
      buf_out_ready = 1'b0;
      if (tx_st_q == LINE_IDLE) begin
         if (tx_en && buf_out_valid) begin // R19
            buf_out_ready = 1'b1; // R20
            tx_sh_d = buf_out_data & len_mask;
            tx_st_d = LINE_START; // R6
            tx_cnt_d = 6'h00;
            tx_idx_d = 4'h0;
         end
      end else if (tick) begin
         tx_cnt_d = tx_cnt_q + 6'h01;
         unique case (tx_st_q)
            LINE_START: if (tx_cnt_q == `SER_LAST_TICK) begin
               tx_cnt_d = 6'h00;
               tx_st_d = LINE_DATA;
            end
            LINE_DATA: if (tx_cnt_q == `SER_LAST_TICK) begin
               tx_cnt_d = 6'h00;
               tx_idx_d = tx_idx_q + 4'h1;
               if (tx_idx_q == char_len - 4'h1) begin
                  tx_st_d = mode1_q[`SER_M1_PAREN] ? LINE_PARITY : LINE_STOP; // R7
               end
            end
            LINE_PARITY: if (tx_cnt_q == `SER_LAST_TICK) begin
               tx_cnt_d = 6'h00;
               tx_st_d = LINE_STOP;
            end
            LINE_STOP: if (tx_cnt_q == stop_ticks - 6'h01) begin // R6
               tx_st_d = LINE_IDLE;
            end
            default: tx_st_d = LINE_IDLE;
         endcase
      end
      unique case (tx_st_d)
         LINE_START: tx_bit = 1'b0;
         LINE_DATA: tx_bit = tx_sh_d[tx_idx_d[2:0]];
         LINE_PARITY: tx_bit = calc_parity(tx_sh_d, mode1_q[`SER_M1_PAREVEN]);
         default: tx_bit = 1'b1;
      endcase
      // Break holds the line at spacing so the far end sees a long zero.
      txd_d = cmd_d[`SER_CMD_BREAK] ? 1'b0 : tx_bit;
      tx_free = tx_en && !buf_out_valid; // R8
      tx_empty = (tx_st_q == LINE_IDLE) && !buf_out_valid;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         tx_st_q <= LINE_IDLE;
         tx_cnt_q <= 6'h00;
         tx_idx_q <= 4'h0;
         tx_sh_q <= `SER_RESET_BYTE;
         txd_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_cnt_q <= tx_cnt_d;
         tx_idx_q <= tx_idx_d;
         tx_sh_q <= tx_sh_d;
         txd_q <= txd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver. Bits are sampled at the middle tick of each sixteen.
   line_state_t rx_st_q, rx_st_d;
   logic [5:0] rx_cnt_q, rx_cnt_d;
   logic [3:0] rx_idx_q, rx_idx_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic rx_par_bad_q, rx_par_bad_d;
   logic rx_done, rx_frame_bad;

   always_comb begin
      rx_st_d = rx_st_q;
      rx_cnt_d = rx_cnt_q;
      rx_idx_d = rx_idx_q;
      rx_sh_d = rx_sh_q;
      rx_par_bad_d = rx_par_bad_q;
      rx_done = 1'b0;
      rx_frame_bad = 1'b0;
      if (!rx_en) begin
         rx_st_d = LINE_IDLE; // R19
      end else if (tick) begin
         rx_cnt_d = rx_cnt_q + 6'h01;
         unique case (rx_st_q)
            LINE_IDLE: begin
               rx_cnt_d = 6'h00;
               if (!rxd) begin
                  rx_st_d = LINE_START;
                  rx_sh_d = `SER_RESET_BYTE;
                  rx_idx_d = 4'h0;
                  rx_par_bad_d = 1'b0;
               end
            end
            LINE_START: begin
               // A start bit that is gone by mid-bit was noise, not a character.
               if (rx_cnt_q == `SER_MID_TICK && rxd) begin
                  rx_st_d = LINE_IDLE;
               end else if (rx_cnt_q == `SER_LAST_TICK) begin
                  rx_cnt_d = 6'h00;
                  rx_st_d = LINE_DATA;
               end
            end
            LINE_DATA: begin
               if (rx_cnt_q == `SER_MID_TICK) begin
                  rx_sh_d[rx_idx_q[2:0]] = rxd;
               end
               if (rx_cnt_q == `SER_LAST_TICK) begin
                  rx_cnt_d = 6'h00;
                  rx_idx_d = rx_idx_q + 4'h1;
                  if (rx_idx_q == char_len - 4'h1) begin
                     rx_st_d = mode1_q[`SER_M1_PAREN] ? LINE_PARITY : LINE_STOP;
                  end
               end
            end
            LINE_PARITY: begin
               if (rx_cnt_q == `SER_MID_TICK) begin
                  rx_par_bad_d = rxd != calc_parity(rx_sh_q, mode1_q[`SER_M1_PAREVEN]);
               end
               if (rx_cnt_q == `SER_LAST_TICK) begin
                  rx_cnt_d = 6'h00;
                  rx_st_d = LINE_STOP;
               end
            end
            LINE_STOP: if (rx_cnt_q == `SER_MID_TICK) begin
               rx_done = 1'b1; // R6
               rx_frame_bad = !rxd; // R14
               rx_st_d = LINE_IDLE;
            end
            default: rx_st_d = LINE_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rx_st_q <= LINE_IDLE;
         rx_cnt_q <= 6'h00;
         rx_idx_q <= 4'h0;
         rx_sh_q <= `SER_RESET_BYTE;
         rx_par_bad_q <= 1'b0;
      end else begin
         rx_st_q <= rx_st_d;
         rx_cnt_q <= rx_cnt_d;
         rx_idx_q <= rx_idx_d;
         rx_sh_q <= rx_sh_d;
         rx_par_bad_q <= rx_par_bad_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port decode, registers and status flags.
   always_comb begin
      hit = port_addr[7:4] == base_sel; // R1
      wr_data = hit && port_wr && port_addr[3:0] == `SER_OFS_DATA; // R2
      rd_data = hit && port_rd && port_addr[3:0] == `SER_OFS_DATA; // R2
      rd_stat = hit && port_rd && port_addr[3:0] == `SER_OFS_STATUS; // R3
      wr_mode = hit && port_wr && port_addr[3:0] == `SER_OFS_MODE; // R4
      rd_mode = hit && port_rd && port_addr[3:0] == `SER_OFS_MODE; // R4
      wr_cmd = hit && port_wr && port_addr[3:0] == `SER_OFS_CMD; // R5

      status = 8'h00;
      status[`SER_ST_TRANSMIT_HOLDING_FREE] = tx_free; // R8
      status[`SER_ST_RECEIVE_CHAR_AVAILABLE] = rx_avail_q; // R10
      status[`SER_ST_TXEMT] = tx_empty || modem_chg_q; // R11
      status[`SER_ST_PERR] = perr_q; // R12
      status[`SER_ST_OVR] = ovr_q; // R13
      status[`SER_ST_FERR] = ferr_q; // R14
      status[`SER_ST_DCD] = !dcd_n; // R15
      status[`SER_ST_DSR] = !dsr_n; // R16

      mode1_d = mode1_q;
      mode2_d = mode2_q;
      mode_ptr_d = mode_ptr_q ^ (wr_mode || rd_mode); // R18
      if (wr_mode && !mode_ptr_q) begin
         mode1_d = port_wdata; // R18
      end
      if (wr_mode && mode_ptr_q) begin
         mode2_d = port_wdata; // R18
      end
      cmd_d = wr_cmd ? port_wdata : cmd_q; // R5
      rts_n_d = !cmd_d[`SER_CMD_RTS]; // R7
      dtr_n_d = !cmd_d[`SER_CMD_DTR]; // R7

      // Each flag's set term is applied after its clear, so an event never gets lost.
      rx_hold_d = rx_done ? rx_sh_q : rx_hold_q;
      rx_avail_d = (rx_avail_q && !rd_data) || rx_done; // R20
      perr_d = (perr_q && !(wr_cmd && port_wdata[`SER_CMD_ERRCLR]))
         || (rx_done && rx_par_bad_q); // R17 R21 R12
      ovr_d = (ovr_q && !(wr_cmd && port_wdata[`SER_CMD_ERRCLR]))
         || (rx_done && rx_avail_q && !rd_data); // R17 R21 R13
      ferr_d = (ferr_q && !(wr_cmd && port_wdata[`SER_CMD_ERRCLR]))
         || rx_frame_bad; // R17 R21 R14
      modem_chg_d = (modem_chg_q && !rd_stat)
         || (dcd_n != dcd_last_q) || (dsr_n != dsr_last_q); // R11

      rdata_d = 8'h00;
      if (rd_data) begin
         rdata_d = rx_hold_q; // R2
      end else if (rd_stat) begin
         rdata_d = status; // R3
      end else if (rd_mode) begin
         rdata_d = mode_ptr_q ? mode2_q : mode1_q; // R4
      end else if (hit && port_rd && port_addr[3:0] == `SER_OFS_CMD) begin
         rdata_d = cmd_q; // R5
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         mode1_q <= `SER_RESET_BYTE;
         mode2_q <= `SER_RESET_BYTE;
         cmd_q <= `SER_RESET_BYTE;
         mode_ptr_q <= 1'b0;
         rx_hold_q <= `SER_RESET_BYTE;
         rx_avail_q <= 1'b0;
         perr_q <= 1'b0;
         ovr_q <= 1'b0;
         ferr_q <= 1'b0;
         modem_chg_q <= 1'b0;
         dcd_last_q <= 1'b1;
         dsr_last_q <= 1'b1;
         port_rdata_q <= 8'h00;
         rts_n_q <= 1'b1;
         dtr_n_q <= 1'b1;
      end else begin
         mode1_q <= mode1_d;
         mode2_q <= mode2_d;
         cmd_q <= cmd_d;
         mode_ptr_q <= mode_ptr_d;
         rx_hold_q <= rx_hold_d;
         rx_avail_q <= rx_avail_d;
         perr_q <= perr_d;
         ovr_q <= ovr_d;
         ferr_q <= ferr_d;
         modem_chg_q <= modem_chg_d;
         dcd_last_q <= dcd_n;
         dsr_last_q <= dsr_n;
         port_rdata_q <= rdata_d;
         rts_n_q <= rts_n_d;
         dtr_n_q <= dtr_n_d;
      end
   end
endmodule : serial_channel_register_port

// ### verif/serial_far_end.sv
module serial_far_end #(
   parameter int BIT_CYC = 16
) (
   // Clock.
   input wire logic clock,
   // Serial line from and to the block.
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q[$];

   initial rxd = 1'b1;

   // Bits leave LSB first; bit 0 of the frame is the start bit.
   task automatic send(input logic [11:0] frame, input int n);
      for (int i = 0; i < n; i++) begin
         rxd <= frame[i];
         repeat (BIT_CYC) @(posedge clock);
      end
      // One idle bit keeps frames apart so the receiver can resynchronise.
      rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge clock);
   endtask : send

   always begin : catch
      logic [7:0] c;
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clock);
         c[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clock);
      got_q.push_back(c);
   end
endmodule : serial_far_end

// ### verif/serial_channel_assertions.sv
`include "serial_channel_params.svh"
module serial_channel_checker #(
   parameter int CLK_HZ = 50000000
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Host port bus.
   input wire logic [3:0] base_sel,
   input wire logic [7:0] port_addr,
   input wire logic [7:0] port_wdata,
   input wire logic port_wr,
   input wire logic port_rd,
   input wire logic [7:0] port_rdata_q,
   // Serial and modem lines.
   input wire logic rxd,
   input wire logic dcd_n,
   input wire logic dsr_n,
   input wire logic txd_q,
   input wire logic rts_n_q,
   input wire logic dtr_n_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   logic [2:0] dcd_h_q;
   logic [2:0] dsr_h_q;
   logic [7:0] a_st;
   logic [7:0] a_cmd;
   logic [7:0] a_dat;
   assign a_st = {base_sel, `SER_OFS_STATUS};
   assign a_cmd = {base_sel, `SER_OFS_CMD};
   assign a_dat = {base_sel, `SER_OFS_DATA};

   // Modem inputs may pass a synchroniser, so only steady levels are judged.
   always_ff @(posedge clock) begin
      dcd_h_q <= {dcd_h_q[1:0], dcd_n};
      dsr_h_q <= {dsr_h_q[1:0], dsr_n};
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_idle_zero;
      !(port_rd && port_addr[7:4] == base_sel && port_addr[3:2] == 2'b11)
         |=> port_rdata_q == 8'h00;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("read data not zero outside a channel read");
   property p_carrier;
      port_rd && port_addr == a_st && dcd_h_q == {3{dcd_n}}
         |=> port_rdata_q[6] == !$past(dcd_n);
   endproperty
   a_carrier: assert property (p_carrier)
      else $error("status bit 6 not inverted carrier");
   property p_dsr;
      port_rd && port_addr == a_st && dsr_h_q == {3{dsr_n}}
         |=> port_rdata_q[7] == !$past(dsr_n);
   endproperty
   a_dsr: assert property (p_dsr)
      else $error("status bit 7 not inverted data set ready");
   property p_cmd_back;
      port_wr && port_addr == a_cmd ##1 port_rd && !port_wr && port_addr == a_cmd
         |=> port_rdata_q == $past(port_wdata, 2);
   endproperty
   a_cmd_back: assert property (p_cmd_back)
      else $error("command read back differs");
   property p_tx_busy;
      port_wr && port_addr == a_dat ##1 port_rd && port_addr == a_st |=> !port_rdata_q[0];
   endproperty
   a_tx_busy: assert property (p_tx_busy)
      else $error("transmit free right after a data write");
   property p_start_bit;
      $fell(txd_q) |-> !txd_q [*8];
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("start bit too short");
   property p_rts;
      port_wr && port_addr == a_cmd && port_wdata[5] |-> ##2 !rts_n_q;
   endproperty
   a_rts: assert property (p_rts)
      else $error("request line not low");
   property p_dtr;
      port_wr && port_addr == a_cmd && port_wdata[1] |-> ##2 !dtr_n_q;
   endproperty
   a_dtr: assert property (p_dtr)
      else $error("terminal ready line not low");
endmodule : serial_channel_checker

bind serial_channel_register_port serial_channel_checker #(.CLK_HZ(CLK_HZ)) checker_inst (
   .clock(clock), .resetn(resetn), .base_sel(base_sel), .port_addr(port_addr),
   .port_wdata(port_wdata), .port_wr(port_wr), .port_rd(port_rd),
   .port_rdata_q(port_rdata_q), .rxd(rxd), .dcd_n(dcd_n), .dsr_n(dsr_n),
   .txd_q(txd_q), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q)
);

// ### verif/serial_channel_register_port_bench.sv
`include "serial_channel_params.svh"
module serial_channel_register_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] BASE = 4'h5;
   localparam logic [7:0] A_DATA = {BASE, `SER_OFS_DATA};
   localparam logic [7:0] A_ST = {BASE, `SER_OFS_STATUS};
   localparam logic [7:0] A_MODE = {BASE, `SER_OFS_MODE};
   localparam logic [7:0] A_CMD = {BASE, `SER_OFS_CMD};
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] base_sel = BASE;
   logic [7:0] port_addr = 8'h00;
   logic [7:0] port_wdata = 8'h00;
   logic port_wr = 1'b0;
   logic port_rd = 1'b0;
   logic dcd_n = 1'b0;
   logic dsr_n = 1'b1;
   wire logic rxd;
   logic [7:0] port_rdata_q;
   logic txd_q;
   logic rts_n_q;
   logic dtr_n_q;
   int fail_count = 0;
   int total_checks = 0;

   always #10 clock = ~clock;

   // This clock rate gives a divisor of one at the fastest rate, so a bit is 16 clocks.
   serial_channel_register_port #(.CLK_HZ(307200)) dut (
      .clock(clock), .resetn(resetn), .base_sel(base_sel), .port_addr(port_addr),
      .port_wdata(port_wdata), .port_wr(port_wr), .port_rd(port_rd),
      .port_rdata_q(port_rdata_q), .rxd(rxd), .dcd_n(dcd_n), .dsr_n(dsr_n),
      .txd_q(txd_q), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q)
   );
   serial_far_end #(.BIT_CYC(16)) far (.clock(clock), .txd(txd_q), .rxd(rxd));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic give_up(input string what);
      fail_count++;
      $display("wrong value at %0t ns: %s timed out", $time, what);
      complete_run();
   endtask : give_up

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // A write right after a write waits one edge so the strobe is never set twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (port_wr) begin
         @(posedge clock);
      end
      port_addr <= a;
      port_wdata <= d;
      port_wr <= 1'b1;
      @(posedge clock);
      port_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      port_addr <= a;
      port_rd <= 1'b1;
      @(posedge clock);
      port_rd <= 1'b0;
      @(posedge clock);
      d = port_rdata_q;
   endtask : rd

   task automatic wait_st(input int b, input logic v);
      logic [7:0] s;
      for (int i = 0; i < 400; i++) begin
         rd(A_ST, s);
         if (s[b] === v) begin
            return;
         end
      end
      give_up("status");
   endtask : wait_st

   task automatic wait_sent(input int n);
      for (int i = 0; i < 3000; i++) begin
         if (far.got_q.size() >= n) begin
            return;
         end
         @(posedge clock);
      end
      give_up("serial output");
   endtask : wait_sent

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_setup();
      logic [7:0] d;
      rd(A_CMD, d);
      check(d, 8'h00, "command after reset");
      check({6'h00, rts_n_q, dtr_n_q}, 8'h03, "modem outputs after reset");
      wr(A_MODE, 8'h4E);
      wr(A_MODE, 8'h7F);
      wr(A_CMD, 8'h27);
      rd(A_CMD, d);
      check(d, 8'h27, "command");
      rd(A_MODE, d);
      check(d, 8'h4E, "mode one");
      rd(A_MODE, d);
      check(d, 8'h7F, "mode two");
      check({6'h00, rts_n_q, dtr_n_q}, 8'h00, "modem outputs");
      wr(A_ST, 8'hFF);
      rd(A_ST, d);
      check(d, 8'h45, "status after write");
      rd({BASE, 4'h0}, d);
      check(d, 8'h00, "foreign offset");
      rd({BASE + 4'h1, `SER_OFS_CMD}, d);
      check(d, 8'h00, "other block");
      base_sel <= 4'hA;
      rd({4'hA, `SER_OFS_CMD}, d);
      check(d, 8'h27, "moved base");
      base_sel <= BASE;
      dcd_n <= 1'b1;
      dsr_n <= 1'b0;
      repeat (4) @(posedge clock);
      rd(A_ST, d);
      check(d & 8'hC0, 8'h80, "modem status");
      $display("test setup done");
   endtask : t_setup

   task automatic t_tx();
      logic [7:0] d;
      logic [7:0] exp[3] = '{8'hA5, 8'h3C, 8'hC3};
      wr(A_CMD, 8'h26);
      wr(A_DATA, exp[0]);
      repeat (40) @(posedge clock);
      rd(A_ST, d);
      check(d & 8'h05, 8'h00, "free while disabled");
      check(8'(far.got_q.size()), 8'h00, "frames while disabled");
      wr(A_CMD, 8'h27);
      wait_st(0, 1'b1);
      wr(A_DATA, exp[1]);
      rd(A_ST, d);
      check(d & 8'h01, 8'h00, "free after write");
      wait_st(0, 1'b1);
      wr(A_DATA, exp[2]);
      wait_sent(3);
      for (int i = 0; i < 3; i++) begin
         check(far.got_q[i], exp[i], "sent character");
      end
      $display("test transmit done");
   endtask : t_tx

   task automatic t_rx();
      logic [7:0] d;
      far.send({3'b111, 8'h5A, 1'b0}, 10);
      wait_st(1, 1'b1);
      rd(A_DATA, d);
      check(d, 8'h5A, "received character");
      rd(A_ST, d);
      check(d & 8'h3A, 8'h00, "status after read");
      far.send({3'b111, 8'h11, 1'b0}, 10);
      far.send({3'b111, 8'h22, 1'b0}, 10);
      rd(A_ST, d);
      check(d & 8'h3A, 8'h12, "overrun");
      rd(A_DATA, d);
      check(d, 8'h22, "newest character");
      far.send({3'b110, 8'h33, 1'b0}, 10);
      rd(A_ST, d);
      check(d & 8'h38, 8'h30, "framing");
      rd(A_ST, d);
      check(d & 8'h38, 8'h30, "flags held");
      rd(A_DATA, d);
      wr(A_CMD, 8'h37);
      rd(A_ST, d);
      check(d & 8'h38, 8'h00, "flags cleared");
      wr(A_MODE, 8'h7E);
      wr(A_MODE, 8'h7F);
      far.send({3'b110, 8'h01, 1'b0}, 11);
      rd(A_ST, d);
      check(d & 8'h3A, 8'h0A, "parity");
      rd(A_DATA, d);
      check(d, 8'h01, "character with bad parity");
      $display("test receive done");
   endtask : t_rx

   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      t_setup();
      t_tx();
      t_rx();
      complete_run();
   end
endmodule : serial_channel_register_port_bench
